// >>> verilog/rsh_params.svh
`ifndef RSH_PARAMS_SVH
`define RSH_PARAMS_SVH
// Summary of operation
// - declare input loss after three or more consecutive missing expected edges, per input
// - each detector compares input against clock divided by 5-bit monitor divider
// - loss sets live and sticky per-input bits; interrupt may be raised
// - detection runs only when first PLL bypass is 0; edges only
// - failed input valid again after revalidation_count consecutive toggling periods
// - mode decoded from holdover_disable and 2-bit select mode field
// - manual modes take selection from select pin or internal bit
// - manual holdover control: user change enters holdover, switches at countdown expiry
// - manual holdover control: active loss changes nothing; reference status 0 while invalid
// - plain manual: loss keeps selection; user change switches at once
// - automatic: active loss switches to other input without holdover; user change immediate
// - automatic with no valid input: no switch, no holdover; lock once revalidated
// - short-term holdover: loss never switches, user change switches at once; holdover while selected input fails
// - holdover time is start value times clock divider; flag low during holdover
// - automatic with holdover: active loss starts holdover, drops reference bits, starts countdown
// - both inputs stay monitored during countdown
// - active revalidation during countdown restores live flag, selection unchanged
// - expiry with active valid: keep selection, reference status 1, leave holdover
// - expiry with other valid: select other, reference status 1, leave holdover
// - expiry with none valid: keep selection, status low, stay in holdover, sticky stays
// - sticky bits cleared by writing 1, only once condition is gone
// - after hold-off sequence revert only if revertive enable is 1
// - counter reloads start value on expiry; clocked only while switch pending
// - revertive switch only to higher-priority revalidated input; disabled by default
`define RSH_LOSS_EDGES 3'h3
`define RSH_REG_CTRL 4'h0
`define RSH_REG_CNT 4'h1
`define RSH_REG_STAT 4'h2
`define RSH_REG_STICKY 4'h3
`define RSH_CTRL_RESET 32'h0000_0000
`define RSH_CNT_RESET 32'h0000_0002
`endif

// >>> verilog/rsh_pkg.sv
package rsh_pkg;
  typedef enum logic [2:0] {
    RSH_MODE_MANHOLD = 3'h0,
    RSH_MODE_MANUAL = 3'h1,
    RSH_MODE_AUTO = 3'h3,
    RSH_MODE_SHORT = 3'h2,
    RSH_MODE_AUTOHOLD = 3'h6
  } rsh_mode_type;
endpackage

// >>> verilog/rsh_loss_monitor.sv
`timescale 1ns/100ps
`include "rsh_params.svh"
module rsh_loss_monitor (
  input wire logic clock,
  input wire logic rstn,
  input wire logic enable,
  input wire logic refTick,
  input wire logic clkSync,
  input wire logic [7:0] revalidationCount,
  output logic lossLive
);
  logic prev_q;
  logic seen_q;
  logic [2:0] miss_q;
  logic [7:0] good_q;
  wire edgeSeen = clkSync & ~prev_q;

  always_ff @(posedge clock or negedge rstn)
    if (!rstn)
      prev_q <= 1'b0;
    else
      prev_q <= clkSync;

  // an edge within each divided-clock window counts as present
  always_ff @(posedge clock or negedge rstn)
    if (!rstn)
    begin
      seen_q <= 1'b0;
      miss_q <= 3'h0;
      good_q <= 8'h00;
      lossLive <= 1'b0;
    end
    else if (!enable)
    begin
      seen_q <= 1'b0;
      miss_q <= 3'h0;
      good_q <= 8'h00;
      lossLive <= 1'b0;
    end
    else
    begin
      seen_q <= refTick ? edgeSeen : (seen_q | edgeSeen);
      if (refTick)
      begin
        if (seen_q | edgeSeen)
        begin
          miss_q <= 3'h0;
          if (lossLive)
          begin
            if (good_q + 8'h01 >= revalidationCount)
            begin
              lossLive <= 1'b0;
              good_q <= 8'h00;
            end
            else
              good_q <= good_q + 8'h01;
          end
        end
        else
        begin
          good_q <= 8'h00;
          if (miss_q != `RSH_LOSS_EDGES)
            miss_q <= miss_q + 3'h1;
          if (miss_q + 3'h1 >= `RSH_LOSS_EDGES)
            lossLive <= 1'b1;
        end
      end
    end
endmodule // rsh_loss_monitor

// >>> verilog/reference_select_holdover.sv
// Design decisions made here: register access over Avalon-MM and the register offsets.
`timescale 1ns/100ps
`include "rsh_params.svh"
module reference_select_holdover (
  input wire logic clock,
  input wire logic rstn,
  input wire logic [3:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic refClk0,
  input wire logic refClk1,
  input wire logic selectPin,
  output logic [1:0] selectedInput,
  output logic holdoverActive,
  output logic interruptOutLow
);
  // ctrl: [4:0] monitor_divider, [5] first_pll_bypass, [6] holdover_disable, [8:7] select_mode_field,
  // [9] external/internal source, [10] internal select, [11] revertive_enable, [12] priority input1 higher
  // cnt: [7:0] revalidation_count, [15:8] holdoff_start_value, [31:16] holdoff_clock_divider
  logic [31:0] ctrl_q;
  logic [31:0] cnt_q;
  logic sync1_q;
  logic sync2_q;
  logic [4:0] monDiv_q;
  logic refTick;
  logic [1:0] inputLossLive;
  logic [1:0] inputLossSticky_q;
  logic [1:0] lossPrev_q;
  logic refLive_q;
  logic refSticky_q;
  logic sel_q;
  logic userSelPrev_q;
  logic hold_q;
  logic pending_q;
  logic [7:0] holdCnt_q;
  logic [15:0] preDiv_q;
  logic ack;
  logic [15:0] preLoad;
  rsh_pkg::rsh_mode_type mode;
  logic userSel;
  logic userChange;
  logic activeLoss;
  logic otherValid;
  logic activeValid;
  logic holdTick;
  logic expiry;
  logic bypass;
  logic [1:0] lossRise;
  logic stickyClr;

  assign bypass = ctrl_q[5];
  always_comb
    case ({ctrl_q[6], ctrl_q[8:7]})
      3'h4: mode = rsh_pkg::RSH_MODE_MANUAL;
      3'h5: mode = rsh_pkg::RSH_MODE_AUTO;
      3'h6: mode = rsh_pkg::RSH_MODE_SHORT;
      3'h7: mode = rsh_pkg::RSH_MODE_AUTOHOLD;
      default: mode = rsh_pkg::RSH_MODE_MANHOLD;
    endcase
  assign userSel = ctrl_q[9] ? sync2_q : ctrl_q[10];
  assign userChange = userSel != userSelPrev_q;
  assign activeValid = ~inputLossLive[sel_q];
  assign otherValid = ~inputLossLive[~sel_q];
  assign activeLoss = inputLossLive[sel_q];
  assign lossRise = inputLossLive & ~lossPrev_q;
  assign holdTick = pending_q && (preDiv_q == 16'h0000);
  // expiry falls on the tick taken at a count of one, which reloads the start value, so holdover lasts start value times divider
  assign expiry = holdTick && (holdCnt_q <= 8'h01);
  assign stickyClr = ack && write && address == `RSH_REG_STICKY;
  assign ack = ~waitrequest;
  assign preLoad = (cnt_q[31:16] == 16'h0000) ? 16'h0000 : cnt_q[31:16] - 16'h0001;

  // select pin synchroniser; the first flop is read only by the second
  always_ff @(posedge clock or negedge rstn)
    if (!rstn)
    begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
    end
    else
    begin
      sync1_q <= selectPin;
      sync2_q <= sync1_q;
    end

  logic [1:0] c1_q;
  logic [1:0] c2_q;
  always_ff @(posedge clock or negedge rstn)
    if (!rstn)
    begin
      c1_q <= 2'b00;
      c2_q <= 2'b00;
    end
    else
    begin
      c1_q <= {refClk1, refClk0};
      c2_q <= c1_q;
    end

  always_ff @(posedge clock or negedge rstn)
    if (!rstn)
      monDiv_q <= 5'h00;
    else if (monDiv_q + 5'h01 >= ctrl_q[4:0])
      monDiv_q <= 5'h00;
    else
      monDiv_q <= monDiv_q + 5'h01;
  assign refTick = monDiv_q == 5'h00;

  genvar g;
  generate
    for (g = 0; g < 2; g++)
    begin : gMon
      rsh_loss_monitor uMon (
        .clock(clock),
        .rstn(rstn),
        .enable(~bypass),
        .refTick(refTick),
        .clkSync(c2_q[g]),
        .revalidationCount(cnt_q[7:0]),
        .lossLive(inputLossLive[g])
      );
    end
  endgenerate

  always_ff @(posedge clock or negedge rstn)
    if (!rstn)
      lossPrev_q <= 2'b00;
    else
      lossPrev_q <= inputLossLive;

  // set wins over clear; clear only once condition is gone
  always_ff @(posedge clock or negedge rstn)
    if (!rstn)
      inputLossSticky_q <= 2'b00;
    else
    begin
      for (int i = 0; i < 2; i++)
        if (lossRise[i])
          inputLossSticky_q[i] <= 1'b1;
        else if (stickyClr && writedata[i] && !inputLossLive[i])
          inputLossSticky_q[i] <= 1'b0;
    end

  // live reference status, low when the selected input is invalid or in holdover of automatic-with-holdover mode
  always_ff @(posedge clock or negedge rstn)
    if (!rstn)
      refLive_q <= 1'b0;
    else
      refLive_q <= activeValid && !(hold_q && mode == rsh_pkg::RSH_MODE_AUTOHOLD);

  always_ff @(posedge clock or negedge rstn)
    if (!rstn)
      refSticky_q <= 1'b0;
    else if (activeLoss && !lossPrev_q[sel_q])
      refSticky_q <= 1'b1;
    else if (stickyClr && writedata[2] && activeValid && !hold_q)
      refSticky_q <= 1'b0;

  always_ff @(posedge clock or negedge rstn)
    if (!rstn)
      userSelPrev_q <= 1'b0;
    else
      userSelPrev_q <= userSel;

  // selection state machine and holdover
  always_ff @(posedge clock or negedge rstn)
    if (!rstn)
    begin
      sel_q <= 1'b0;
      hold_q <= 1'b0;
      pending_q <= 1'b0;
    end
    else
    begin
      case (mode)
        rsh_pkg::RSH_MODE_MANHOLD:
        begin
          if (userChange)
          begin
            hold_q <= 1'b1;
            pending_q <= 1'b1;
          end
          else if (expiry)
          begin
            sel_q <= userSel;
            hold_q <= 1'b0;
            pending_q <= 1'b0;
          end
        end
        rsh_pkg::RSH_MODE_MANUAL:
        begin
          sel_q <= userSel;
          hold_q <= 1'b0;
          pending_q <= 1'b0;
        end
        rsh_pkg::RSH_MODE_AUTO:
        begin
          hold_q <= 1'b0;
          pending_q <= 1'b0;
          if (userChange)
            sel_q <= userSel;
          else if (activeLoss && otherValid)
            sel_q <= ~sel_q;
          else if (ctrl_q[11] && lossPrev_q[~sel_q] && otherValid && (ctrl_q[12] == ~sel_q))
            sel_q <= ~sel_q;
        end
        rsh_pkg::RSH_MODE_SHORT:
        begin
          pending_q <= 1'b0;
          sel_q <= userSel;
          hold_q <= activeLoss;
        end
        rsh_pkg::RSH_MODE_AUTOHOLD:
        begin
          if (userChange)
          begin
            sel_q <= userSel;
            hold_q <= 1'b0;
            pending_q <= 1'b0;
          end
          else if (!hold_q && activeLoss && lossRise[sel_q])
          begin
            hold_q <= 1'b1;
            pending_q <= 1'b1;
          end
          else if (expiry)
          begin
            if (activeValid)
            begin
              hold_q <= 1'b0;
              pending_q <= 1'b0;
            end
            else if (otherValid)
            begin
              sel_q <= ~sel_q;
              hold_q <= 1'b0;
              pending_q <= 1'b0;
            end
            // none valid: stay in holdover and count again
          end
          else if (!hold_q && ctrl_q[11] && lossPrev_q[~sel_q] && otherValid && (ctrl_q[12] == ~sel_q))
            sel_q <= ~sel_q;
        end
        default:
        begin
          hold_q <= 1'b0;
          pending_q <= 1'b0;
        end
      endcase
    end

  // hold-off prescaler and countdown run only while a switch is pending
  always_ff @(posedge clock or negedge rstn)
    if (!rstn)
    begin
      preDiv_q <= 16'h0000;
      holdCnt_q <= 8'h00;
    end
    else if (!pending_q)
    begin
      preDiv_q <= preLoad;
      holdCnt_q <= cnt_q[15:8];
    end
    else if (preDiv_q == 16'h0000)
    begin
      preDiv_q <= preLoad;
      holdCnt_q <= (holdCnt_q <= 8'h01) ? cnt_q[15:8] : holdCnt_q - 8'h01;
    end
    else
      preDiv_q <= preDiv_q - 16'h0001;

  // registered waitrequest idles high and drops for the one cycle in which a request is taken
  always_ff @(posedge clock or negedge rstn)
    if (!rstn)
      waitrequest <= 1'b1;
    else
      waitrequest <= !((read || write) && waitrequest);

  always_ff @(posedge clock or negedge rstn)
    if (!rstn)
    begin
      ctrl_q <= `RSH_CTRL_RESET;
      cnt_q <= `RSH_CNT_RESET;
    end
    else if (write && ack)
    begin
      if (address == `RSH_REG_CTRL)
        ctrl_q <= writedata;
      else if (address == `RSH_REG_CNT)
        cnt_q <= writedata;
    end

  always_ff @(posedge clock or negedge rstn)
    if (!rstn)
      readdata <= 32'h0000_0000;
    else if (read && waitrequest)
      case (address)
        `RSH_REG_CTRL: readdata <= ctrl_q;
        `RSH_REG_CNT: readdata <= cnt_q;
        `RSH_REG_STAT: readdata <= {26'h000_0000, ~hold_q, refLive_q, 1'b0, sel_q, inputLossLive};
        `RSH_REG_STICKY: readdata <= {29'h0000_0000, refSticky_q, inputLossSticky_q};
        default: readdata <= 32'h0000_0000;
      endcase

  always_ff @(posedge clock or negedge rstn)
    if (!rstn)
    begin
      selectedInput <= 2'b00;
      holdoverActive <= 1'b0;
      interruptOutLow <= 1'b1;
    end
    else
    begin
      selectedInput <= {1'b0, sel_q};
      holdoverActive <= hold_q;
      interruptOutLow <= ~(|inputLossSticky_q | refSticky_q);
    end
endmodule // reference_select_holdover

// >>> tb/rsh_chk.sv
`timescale 1ns/100ps
module rsh_chk (
  input wire logic clock,
  input wire logic rstn,
  input wire logic [3:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  input wire logic [1:0] selectedInput,
  input wire logic holdoverActive,
  input wire logic interruptOutLow
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rstn);
  sequence s_req;
    $rose(read || write);
  endsequence
  sequence s_ans;
    waitrequest ##1 !waitrequest;
  endsequence
  property p_answer;
    s_req |-> s_ans;
  endproperty
  property p_waitOnlyReq;
    !waitrequest |-> (read || write);
  endproperty
  property p_unmapped;
    read && !waitrequest && address > 4'h3 |-> readdata == 32'h0000_0000;
  endproperty
  property p_rdHold;
    !read |=> $stable(readdata);
  endproperty
  property p_selRange;
    selectedInput[1] == 1'b0;
  endproperty
  property p_holdKeep;
    holdoverActive && $past(holdoverActive) |-> $stable(selectedInput);
  endproperty
  property p_holdEnter;
    $rose(holdoverActive) |-> $stable(selectedInput);
  endproperty
  // the clear lands one or two edges after the write, so those edges are excused
  property p_irqSticky;
    !interruptOutLow && !write && !$past(write) |=> !interruptOutLow;
  endproperty
  a_answer:
    assert property (p_answer) else $error("waitrequest sequence wrong");
  a_waitOnlyReq:
    assert property (p_waitOnlyReq) else $error("waitrequest low without request");
  a_unmapped:
    assert property (p_unmapped) else $error("unmapped read not zero");
  a_rdHold:
    assert property (p_rdHold) else $error("readdata changed without read");
  a_selRange:
    assert property (p_selRange) else $error("selection out of range");
  a_holdKeep:
    assert property (p_holdKeep) else $error("selection moved in holdover");
  a_holdEnter:
    assert property (p_holdEnter) else $error("selection moved entering holdover");
  a_irqSticky:
    assert property (p_irqSticky) else $error("interrupt released without write");
endmodule // rsh_chk

bind reference_select_holdover rsh_chk u_chk (
  .clock(clock),
  .rstn(rstn),
  .address(address),
  .read(read),
  .write(write),
  .readdata(readdata),
  .waitrequest(waitrequest),
  .selectedInput(selectedInput),
  .holdoverActive(holdoverActive),
  .interruptOutLow(interruptOutLow)
);

// >>> tb/rsh_ref_source.sv
`timescale 1ns/100ps
module rsh_ref_source #(parameter int HALF = 200) (
  input wire logic en0,
  input wire logic en1,
  output logic refClk0,
  output logic refClk1
);
  initial refClk0 = 1'b0;
  initial refClk1 = 1'b0;
  // one edge per divided window; a failed source sticks at its level
  always #(HALF) if (en0) refClk0 = ~refClk0;
  // second source offset in phase so the two never toggle together
  initial #57 forever #(HALF) if (en1) refClk1 = ~refClk1;
endmodule // rsh_ref_source

// >>> tb/reference_select_holdover_tb.sv
`timescale 1ns/100ps
module reference_select_holdover_tb;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic [3:0] address = 4'h0;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0000_0000;
  logic [31:0] readdata;
  logic waitrequest;
  logic refClk0;
  logic refClk1;
  logic en0 = 1'b1;
  logic en1 = 1'b1;
  logic selectPin = 1'b0;
  logic [1:0] selectedInput;
  logic holdoverActive;
  logic interruptOutLow;
  logic [31:0] expQ[$];
  logic [31:0] mskQ[$];
  logic [31:0] seed = 32'h0000_F37B;
  int err_total = 0;
  int n_checks = 0;
  int n;
  always #50 clock = ~clock;
  reference_select_holdover DUT (.clock(clock), .rstn(rstn), .address(address), .read(read), .write(write),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest), .refClk0(refClk0),
    .refClk1(refClk1), .selectPin(selectPin), .selectedInput(selectedInput),
    .holdoverActive(holdoverActive), .interruptOutLow(interruptOutLow));
  rsh_ref_source SRC (.en0(en0), .en1(en1), .refClk0(refClk0), .refClk1(refClk1));
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask
  task automatic results();
    $display("checks %0d, mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clock);
    read <= !w;
    write <= w;
    address <= a;
    writedata <= d;
    do
    begin
      @(posedge clock);
      k++;
    end
    while (waitrequest !== 1'b0 && k < 20);
    read <= 1'b0;
    write <= 1'b0;
    if (k >= 20)
    begin
      err_total++;
      results();
    end
  endtask
  // the monitor below pops these notes as each read completes
  task automatic rd(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
    expQ.push_back(e & m);
    mskQ.push_back(m);
    bus(1'b0, a, 32'h0000_0000);
  endtask
  task automatic waitHold(input logic v);
    n = 0;
    while (holdoverActive !== v && n < 200)
    begin
      @(posedge clock);
      n++;
    end
    if (n >= 200)
    begin
      err_total++;
      results();
    end
  endtask
  always @(posedge clock)
  begin
    if (read === 1'b1 && waitrequest === 1'b0 && expQ.size() > 0)
      check(readdata & mskQ.pop_front(), expQ.pop_front(), "readdata");
  end
  initial
  begin
    repeat (2) @(posedge clock);
    rstn <= 1'b1;
    rd(4'h0, 32'h0000_0000, 32'hFFFF_FFFF);
    rd(4'h1, 32'h0000_0002, 32'hFFFF_FFFF);
    rd(4'h2, 32'h0000_0020, 32'h0000_0024);
    bus(1'b1, 4'hF, xs());
    rd(4'hF, 32'h0000_0000, 32'hFFFF_FFFF);
    rd(4'h0, 32'h0000_0000, 32'hFFFF_FFFF);
    $display("test reset and unmapped done");
    bus(1'b1, 4'h1, 32'h0004_0402);
    // monitors held in bypass first so both inputs start valid together
    bus(1'b1, 4'h0, 32'h0000_0024);
    bus(1'b1, 4'h0, 32'h0000_00C4);
    repeat (60) @(posedge clock);
    bus(1'b1, 4'h3, 32'h0000_0007);
    rd(4'h2, 32'h0000_0030, 32'h0000_0037);
    en0 <= 1'b0;
    repeat (40) @(posedge clock);
    rd(4'h2, 32'h0000_0035, 32'h0000_0037);
    rd(4'h3, 32'h0000_0001, 32'h0000_0003);
    check(32'(interruptOutLow), 32'h0000_0000, "interruptOutLow");
    en0 <= 1'b1;
    repeat (40) @(posedge clock);
    rd(4'h2, 32'h0000_0034, 32'h0000_0037);
    rd(4'h3, 32'h0000_0001, 32'h0000_0003);
    bus(1'b1, 4'h3, 32'h0000_0007);
    rd(4'h3, 32'h0000_0000, 32'h0000_0007);
    check(32'(interruptOutLow), 32'h0000_0001, "interruptOutLow");
    $display("test automatic done");
    bus(1'b1, 4'h0, 32'h0000_01C4);
    en1 <= 1'b0;
    waitHold(1'b1);
    waitHold(1'b0);
    check(32'(n >= 14 && n <= 18), 32'h0000_0001, "holdoff length");
    rd(4'h2, 32'h0000_0032, 32'h0000_0036);
    check(32'(selectedInput), 32'h0000_0000, "selectedInput");
    en1 <= 1'b1;
    repeat (40) @(posedge clock);
    en0 <= 1'b0;
    en1 <= 1'b0;
    waitHold(1'b1);
    repeat (60) @(posedge clock);
    check(32'(holdoverActive), 32'h0000_0001, "holdoverActive");
    bus(1'b1, 4'h3, 32'h0000_0007);
    rd(4'h3, 32'h0000_0004, 32'h0000_0004);
    rd(4'h2, 32'h0000_0003, 32'h0000_0037);
    $display("test automatic holdover done");
    // a second reset clears the stuck holdover left by the no-input case
    rstn <= 1'b0;
    en0 <= 1'b1;
    en1 <= 1'b1;
    repeat (2) @(posedge clock);
    rstn <= 1'b1;
    bus(1'b1, 4'h1, 32'h0004_0402);
    bus(1'b1, 4'h0, 32'h0000_0204);
    repeat (60) @(posedge clock);
    selectPin <= 1'b1;
    waitHold(1'b1);
    check(32'(selectedInput), 32'h0000_0000, "selectedInput");
    waitHold(1'b0);
    check(32'(selectedInput), 32'h0000_0001, "selectedInput");
    bus(1'b1, 4'h0, 32'h0000_0044);
    repeat (3) @(posedge clock);
    check(32'(selectedInput), 32'h0000_0000, "selectedInput");
    en0 <= 1'b0;
    repeat (40) @(posedge clock);
    check(32'({selectedInput, holdoverActive}), 32'h0000_0000, "selection and holdover");
    en0 <= 1'b1;
    repeat (40) @(posedge clock);
    bus(1'b1, 4'h0, 32'h0000_0144);
    en0 <= 1'b0;
    waitHold(1'b1);
    en0 <= 1'b1;
    waitHold(1'b0);
    check(32'(selectedInput), 32'h0000_0000, "selectedInput");
    $display("test manual modes done");
    results();
  end
endmodule // reference_select_holdover_tb
